// ### verilog/amvc_params.svh
// Purpose: offsets, reset values, codes and timing for the volume/mute control
// Assumes: 50 MHz core clock
// Notes: definitions only
`ifndef AMVC_PARAMS_SVH
`define AMVC_PARAMS_SVH
// ===========================================================================
// register sub-addresses
`define AMVC_OFS_SYSCTL1 8'h03
`define AMVC_OFS_SERFMT 8'h04
`define AMVC_OFS_SYSCTL2 8'h05
`define AMVC_OFS_SOFTMUTE 8'h06
`define AMVC_OFS_MASTERVOL 8'h07
`define AMVC_OFS_CH1VOL 8'h08
`define AMVC_OFS_CH2VOL 8'h09
`define AMVC_OFS_SLEWCFG 8'h0E
// ===========================================================================
// reset values
`define AMVC_RST_SYSCTL1 8'h80
`define AMVC_RST_SERFMT 8'h05
`define AMVC_RST_SYSCTL2 8'h40
`define AMVC_RST_SOFTMUTE 8'h00
`define AMVC_RST_SLEWCFG 8'hF0
`define AMVC_VOL_MUTE 16'h03FF
`define AMVC_VOL_0DB 16'h00C0
// ===========================================================================
// field positions
`define AMVC_BIT_HARDUNMUTE 5
`define AMVC_BIT_SHUTDOWN 6
`define AMVC_BIT_TERNARY 3
`define AMVC_BIT_FAULTOUT 1
// ===========================================================================
// slew length codes and their step count as a power of two
`define AMVC_SLEW_512 3'h0
`define AMVC_SLEW_1024 3'h1
`define AMVC_SLEW_2048 3'h2
`define AMVC_SLEW_256 3'h3
`define AMVC_LOG2_512 4'h9
`define AMVC_LOG2_1024 4'hA
`define AMVC_LOG2_2048 4'hB
`define AMVC_LOG2_256 4'h8
// ===========================================================================
// step period per sample-rate family, in ns, and the clock rate
`define AMVC_STEP_8K_NS 125000
`define AMVC_STEP_44K_NS 90700
`define AMVC_STEP_48K_NS 83300
`define AMVC_CLK_MHZ 50
`endif

// ### verilog/amvc_pkg.sv
// Purpose: types shared by the volume/mute control
// Assumes: nothing
// Notes: constants live in amvc_params.svh
package amvc_pkg;
   // serial framing
   typedef enum logic [1:0] {FMT_RJ = 2'h0, FMT_I2S = 2'h1, FMT_LJ = 2'h2} amvc_fmt_t;
   // received word length
   typedef enum logic [1:0] {WL_16 = 2'h0, WL_20 = 2'h1, WL_24 = 2'h2} amvc_wlen_t;
   // shutdown sequencer, one-hot
   typedef enum logic [2:0]
   {
      ST_SHUT = 3'b001,
      ST_UNMUTE = 3'b010,
      ST_RUN = 3'b100
   } amvc_state_t;
   // sample-rate family reported by the clock detector
   typedef enum logic [1:0] {FS_8K = 2'h0, FS_44K = 2'h1, FS_48K = 2'h2} amvc_fs_t;
endpackage

// ### verilog/amvc_ramp_if.sv
// Purpose: link between the control core and one gain ramp
// Assumes: single clock
// Notes: ctrl drives target and pacing, ramp returns gain
`timescale 1ns/1ps
interface amvc_ramp_if;
   logic [15:0] target;
   logic hard;
   logic stepTick;
   logic [3:0] stepLog2;
   logic [15:0] gain;
   logic done;
   modport ctrl (output target, output hard, output stepTick, output stepLog2,
                 input gain, input done);
   modport ramp (input target, input hard, input stepTick, input stepLog2,
                 output gain, output done);
endinterface

// ### verilog/amvc_vol_ramp.sv
// Purpose: moves one applied gain code toward its target in ramp steps
// Assumes: stepTick is a one-cycle pulse
// Notes: step size is fixed when the target changes
`timescale 1ns/1ps
`include "amvc_params.svh"
module amvc_vol_ramp
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] resetGain,
   amvc_ramp_if.ramp rp
);
   logic [15:0] gain_q;
   logic [15:0] delta_q;
   logic [15:0] lastTarget_q;
   logic [16:0] diff;
   logic [16:0] rounded;
   logic [15:0] deltaNew;
   logic [15:0] deltaUse;

   // ceil(|target-gain| / 2^log2), at least one code per step
   always_comb
   begin
      diff = (rp.target > gain_q) ? {1'b0, rp.target - gain_q} : {1'b0, gain_q - rp.target};
      rounded = (diff + ((17'h0_0001 << rp.stepLog2) - 17'h0_0001)) >> rp.stepLog2;
      deltaNew = (rounded[15:0] == 16'h0000) ? 16'h0001 : rounded[15:0];
      // a tick on the change edge must not use the old step size
      deltaUse = (rp.target != lastTarget_q) ? deltaNew : delta_q;
   end

   // latch a fresh step size when the target moves
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         lastTarget_q <= `AMVC_VOL_MUTE;
         delta_q <= 16'h0001;
      end
      else if (rp.target != lastTarget_q)
      begin
         lastTarget_q <= rp.target;
         delta_q <= deltaNew;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         gain_q <= resetGain;
      else if (rp.hard)
         gain_q <= rp.target;
      else if (rp.stepTick && (gain_q != rp.target))
      begin
         if (diff <= {1'b0, deltaUse})
            gain_q <= rp.target;
         else if (rp.target > gain_q)
            gain_q <= gain_q + deltaUse;
         else
            gain_q <= gain_q - deltaUse;
      end
   end

   assign rp.gain = gain_q;
   assign rp.done = (gain_q == rp.target);
endmodule // amvc_vol_ramp

// ### verilog/amvc_ctrl.sv
// Purpose: format, shutdown, modulation, pin-direction, mute and volume control
// Assumes: register port and audio path share the 50 MHz clock
// Notes: gain codes are attenuation in 0.125 dB units from +24 dB
`timescale 1ns/1ps
`include "amvc_params.svh"
module amvc_ctrl
#(
   parameter int STEP_8K_CYC = `AMVC_STEP_8K_NS * `AMVC_CLK_MHZ / 1000,
   parameter int STEP_44K_CYC = `AMVC_STEP_44K_NS * `AMVC_CLK_MHZ / 1000,
   parameter int STEP_48K_CYC = `AMVC_STEP_48K_NS * `AMVC_CLK_MHZ / 1000
)
(
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   output logic [15:0] regRdData,
   // audio path side
   input wire amvc_pkg::amvc_fs_t fsFamily,
   input wire logic speakerFault,
   output amvc_pkg::amvc_fmt_t rxFormat,
   output amvc_pkg::amvc_wlen_t rxWordLen,
   output logic fmtCodeReserved,
   output logic allShutdown,
   output logic ternaryMode,
   output logic [2:0] halfDutyMute,
   output logic [15:0] masterGain,
   output logic [15:0] ch1Gain,
   output logic [15:0] ch2Gain,
   output logic rampBusy,
   // shared address / fault pin
   input wire logic addrSelFaultPinIn,
   output logic addrSelFaultPinOut,
   output logic addrSelFaultPinOe,
   output logic busAddrSel
);
   // ========================================================================
   // register storage
   logic [7:0] sysCtl1_q;
   logic [7:0] serFmt_q;
   logic [7:0] sysCtl2_q;
   logic [7:0] softMute_q;
   logic [15:0] masterVol_q;
   logic [15:0] ch1Vol_q;
   logic [15:0] ch2Vol_q;
   logic [7:0] slewCfg_q;
   logic [15:0] rdData_q;
   logic [15:0] rdData_d;

   // software writes, low bits carry byte-wide registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sysCtl1_q <= `AMVC_RST_SYSCTL1;
         serFmt_q <= `AMVC_RST_SERFMT;
         sysCtl2_q <= `AMVC_RST_SYSCTL2;
         softMute_q <= `AMVC_RST_SOFTMUTE;
         masterVol_q <= `AMVC_VOL_MUTE;
         ch1Vol_q <= `AMVC_VOL_0DB;
         ch2Vol_q <= `AMVC_VOL_0DB;
         slewCfg_q <= `AMVC_RST_SLEWCFG;
      end
      else if (regWrEn)
      begin
         case (regAddr)
            `AMVC_OFS_SYSCTL1: sysCtl1_q <= regWrData[7:0];
            `AMVC_OFS_SERFMT: serFmt_q <= regWrData[7:0];
            `AMVC_OFS_SYSCTL2: sysCtl2_q <= regWrData[7:0];
            `AMVC_OFS_SOFTMUTE: softMute_q <= {5'h00, regWrData[2:0]};
            `AMVC_OFS_MASTERVOL: masterVol_q <= regWrData;
            `AMVC_OFS_CH1VOL: ch1Vol_q <= regWrData;
            `AMVC_OFS_CH2VOL: ch2Vol_q <= regWrData;
            `AMVC_OFS_SLEWCFG: slewCfg_q <= regWrData[7:0];
            default: ;
         endcase
      end
   end

   // read mux, unmapped addresses return zero
   always_comb
   begin
      case (regAddr)
         `AMVC_OFS_SYSCTL1: rdData_d = {8'h00, sysCtl1_q};
         `AMVC_OFS_SERFMT: rdData_d = {8'h00, serFmt_q};
         `AMVC_OFS_SYSCTL2: rdData_d = {8'h00, sysCtl2_q};
         `AMVC_OFS_SOFTMUTE: rdData_d = {8'h00, softMute_q};
         `AMVC_OFS_MASTERVOL: rdData_d = masterVol_q;
         `AMVC_OFS_CH1VOL: rdData_d = ch1Vol_q;
         `AMVC_OFS_CH2VOL: rdData_d = ch2Vol_q;
         `AMVC_OFS_SLEWCFG: rdData_d = {8'h00, slewCfg_q};
         default: rdData_d = 16'h0000;
      endcase
   end

   // read data registered one cycle after the address
   always_ff @(posedge clock)
   begin
      if (rst)
         rdData_q <= 16'h0000;
      else
         rdData_q <= rdData_d;
   end
   assign regRdData = rdData_q;

   // ========================================================================
   // serial format decode
   amvc_pkg::amvc_fmt_t fmt_q;
   amvc_pkg::amvc_wlen_t wlen_q;
   logic fmtRes_q;

   // decode; reserved codes keep the last valid framing
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         fmt_q <= amvc_pkg::FMT_I2S;
         wlen_q <= amvc_pkg::WL_24;
         fmtRes_q <= 1'b0;
      end
      else
      begin
         fmtRes_q <= (serFmt_q[3:0] > 4'h8);
         if (serFmt_q[3:0] <= 4'h8)
         begin
            case (serFmt_q[3:0])
               4'h0, 4'h1, 4'h2: fmt_q <= amvc_pkg::FMT_RJ;
               4'h3, 4'h4, 4'h5: fmt_q <= amvc_pkg::FMT_I2S;
               default: fmt_q <= amvc_pkg::FMT_LJ;
            endcase
            case (serFmt_q[3:0])
               4'h0, 4'h3, 4'h6: wlen_q <= amvc_pkg::WL_16;
               4'h1, 4'h4, 4'h7: wlen_q <= amvc_pkg::WL_20;
               default: wlen_q <= amvc_pkg::WL_24;
            endcase
         end
      end
   end
   assign rxFormat = fmt_q;
   assign rxWordLen = wlen_q;
   assign fmtCodeReserved = fmtRes_q;

   // ========================================================================
   // modulation and soft mute flags
   // ternary select
   assign ternaryMode = sysCtl2_q[`AMVC_BIT_TERNARY];
   assign halfDutyMute = softMute_q[2:0];

   // ========================================================================
   // address / fault pin
   logic pinSync1_q;
   logic pinSync2_q;
   logic addrSel_q;

   // pin is asynchronous, two stages before use
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pinSync1_q <= 1'b0;
         pinSync2_q <= 1'b0;
      end
      else
      begin
         pinSync1_q <= addrSelFaultPinIn;
         pinSync2_q <= pinSync1_q;
      end
   end

   // sample address only while the pin is an input
   always_ff @(posedge clock)
   begin
      if (rst)
         addrSel_q <= 1'b0;
      else if (!sysCtl2_q[`AMVC_BIT_FAULTOUT])
         addrSel_q <= pinSync2_q;
   end
   assign busAddrSel = addrSel_q;
   // drive fault when set as output
   assign addrSelFaultPinOe = sysCtl2_q[`AMVC_BIT_FAULTOUT];
   assign addrSelFaultPinOut = sysCtl2_q[`AMVC_BIT_FAULTOUT] & speakerFault;

   // ========================================================================
   // ramp pacing
   logic [3:0] log2_q;
   logic [12:0] stepCnt_q;
   logic [12:0] stepLimit;
   logic stepTick_q;

   // slew length; reserved codes keep the previous length
   always_ff @(posedge clock)
   begin
      if (rst)
         log2_q <= `AMVC_LOG2_512;
      else
      begin
         case (slewCfg_q[2:0])
            `AMVC_SLEW_512: log2_q <= `AMVC_LOG2_512;
            `AMVC_SLEW_1024: log2_q <= `AMVC_LOG2_1024;
            `AMVC_SLEW_2048: log2_q <= `AMVC_LOG2_2048;
            `AMVC_SLEW_256: log2_q <= `AMVC_LOG2_256;
            default: ;
         endcase
      end
   end

   always_comb
   begin
      case (fsFamily)
         amvc_pkg::FS_8K: stepLimit = 13'(STEP_8K_CYC - 1);
         amvc_pkg::FS_44K: stepLimit = 13'(STEP_44K_CYC - 1);
         default: stepLimit = 13'(STEP_48K_CYC - 1);
      endcase
   end

   // step divider, one-cycle tick
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stepCnt_q <= 13'h0000;
         stepTick_q <= 1'b0;
      end
      else if (stepCnt_q >= stepLimit)
      begin
         stepCnt_q <= 13'h0000;
         stepTick_q <= 1'b1;
      end
      else
      begin
         stepCnt_q <= stepCnt_q + 13'h0001;
         stepTick_q <= 1'b0;
      end
   end

   // ========================================================================
   // shutdown sequencer
   amvc_pkg::amvc_state_t state_q;
   logic allDone;
   logic hardNow;
   logic [2:0] doneVec;

   always_ff @(posedge clock)
   begin
      if (rst)
         state_q <= amvc_pkg::ST_SHUT;
      else if (sysCtl2_q[`AMVC_BIT_SHUTDOWN])
         state_q <= amvc_pkg::ST_SHUT;
      else
      begin
         case (state_q)
            amvc_pkg::ST_SHUT: state_q <= amvc_pkg::ST_UNMUTE;
            amvc_pkg::ST_UNMUTE:
               if (allDone)
                  state_q <= amvc_pkg::ST_RUN;
            amvc_pkg::ST_RUN: state_q <= amvc_pkg::ST_RUN;
            default: state_q <= amvc_pkg::ST_SHUT;
         endcase
      end
   end
   assign allShutdown = (state_q == amvc_pkg::ST_SHUT);
   assign allDone = &doneVec;
   assign rampBusy = ~allDone;

   // hard unmute bit picks exit style; shutdown is a hard mute
   assign hardNow = (state_q == amvc_pkg::ST_SHUT) ||
                    ((state_q == amvc_pkg::ST_UNMUTE) && sysCtl1_q[`AMVC_BIT_HARDUNMUTE]);

   // ========================================================================
   // gain ramps: master, channel 1, channel 2
   logic [15:0] targetVec [3];
   logic [15:0] resetVec [3];
   logic [15:0] gainVec [3];

   // muting is a target of mute code on the same ramp
   always_comb
   begin
      targetVec[0] = allShutdown ? `AMVC_VOL_MUTE : masterVol_q;
      targetVec[1] = (allShutdown || softMute_q[0]) ? `AMVC_VOL_MUTE : ch1Vol_q;
      targetVec[2] = (allShutdown || softMute_q[1]) ? `AMVC_VOL_MUTE : ch2Vol_q;
      resetVec[0] = `AMVC_VOL_MUTE;
      resetVec[1] = `AMVC_VOL_MUTE;
      resetVec[2] = `AMVC_VOL_MUTE;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_ramp
         amvc_ramp_if rb ();
         assign rb.target = targetVec[gi];
         assign rb.hard = hardNow;
         assign rb.stepTick = stepTick_q;
         assign rb.stepLog2 = log2_q;
         assign gainVec[gi] = rb.gain;
         assign doneVec[gi] = rb.done;
         amvc_vol_ramp u_ramp
         (
            .clock(clock),
            .rst(rst),
            .resetGain(resetVec[gi]),
            .rp(rb)
         );
      end
   endgenerate

   // gain code out, 24 dB minus code times 0.125 dB
   assign masterGain = gainVec[0];
   assign ch1Gain = gainVec[1];
   assign ch2Gain = gainVec[2];
endmodule // amvc_ctrl

// ### verification/amvc_ctrl_chk.sv
// Purpose: port-level checks of the volume/mute control
// Assumes: single clock, sync active-high reset
// Notes: bound onto amvc_ctrl at the foot of this file
`timescale 1ns/1ps
module amvc_ctrl_chk
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic [15:0] regRdData,
   input wire amvc_pkg::amvc_fmt_t rxFormat,
   input wire amvc_pkg::amvc_wlen_t rxWordLen,
   input wire logic fmtCodeReserved,
   input wire logic allShutdown,
   input wire logic ternaryMode,
   input wire logic [2:0] halfDutyMute,
   input wire logic [15:0] masterGain,
   input wire logic speakerFault,
   input wire logic addrSelFaultPinOut,
   input wire logic addrSelFaultPinOe
);
   // ========================================================================
   // write decode helpers
   logic wrFmt;
   logic wrSys2;
   assign wrFmt = regWrEn && (regAddr == 8'h04);
   assign wrSys2 = regWrEn && (regAddr == 8'h05);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ========================================================================
   // properties, decoded outputs lag the register by one edge
   property p_fmt;
      wrFmt && (regWrData[3:0] <= 4'h8) |-> ##2 ({rxFormat, rxWordLen} ==
         {2'($past(regWrData[3:0], 2) / 4'h3), 2'($past(regWrData[3:0], 2) % 4'h3)});
   endproperty
   a_fmt: assert property (p_fmt) else $error("format decode wrong");
   property p_fmt_rsvd;
      wrFmt && (regWrData[3:0] > 4'h8) |-> ##2 fmtCodeReserved &&
         (rxFormat == $past(rxFormat, 2)) && (rxWordLen == $past(rxWordLen, 2));
   endproperty
   a_fmt_rsvd: assert property (p_fmt_rsvd) else $error("reserved format mishandled");
   property p_shut_on;
      wrSys2 && regWrData[6] |-> ##2 allShutdown;
   endproperty
   a_shut_on: assert property (p_shut_on) else $error("shutdown not entered");
   property p_shut_off;
      wrSys2 && !regWrData[6] |-> ##2 !allShutdown;
   endproperty
   a_shut_off: assert property (p_shut_off) else $error("shutdown not left");
   // hard mute lands one edge after the state turns
   property p_mute_gain;
      allShutdown && $past(allShutdown) |-> (masterGain == 16'h03FF);
   endproperty
   a_mute_gain: assert property (p_mute_gain) else $error("gain not muted in shutdown");
   property p_ternary;
      wrSys2 |=> (ternaryMode == $past(regWrData[3]));
   endproperty
   a_ternary: assert property (p_ternary) else $error("ternary bit not applied");
   property p_pin_oe;
      wrSys2 |=> (addrSelFaultPinOe == $past(regWrData[1]));
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("pin direction wrong");
   property p_pin_out;
      addrSelFaultPinOut == (addrSelFaultPinOe && speakerFault);
   endproperty
   a_pin_out: assert property (p_pin_out) else $error("fault pin level wrong");
   property p_mute_bits;
      regWrEn && (regAddr == 8'h06) |=> (halfDutyMute == $past(regWrData[2:0]));
   endproperty
   a_mute_bits: assert property (p_mute_bits) else $error("half duty flags wrong");
   property p_rd_unmapped;
      ($past(regAddr) == 8'h20) |-> (regRdData == 16'h0000);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
endmodule // amvc_ctrl_chk

bind amvc_ctrl amvc_ctrl_chk chk
(
   .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
   .regRdData(regRdData), .rxFormat(rxFormat), .rxWordLen(rxWordLen),
   .fmtCodeReserved(fmtCodeReserved), .allShutdown(allShutdown), .ternaryMode(ternaryMode),
   .halfDutyMute(halfDutyMute), .masterGain(masterGain), .speakerFault(speakerFault),
   .addrSelFaultPinOut(addrSelFaultPinOut), .addrSelFaultPinOe(addrSelFaultPinOe)
);

// ### verification/amvc_host_model.sv
// Purpose: host that writes and reads the control registers
// Assumes: one-cycle write strobe, read data one edge after the address
// Notes: tasks are called from the bench
`timescale 1ns/1ps
module amvc_host_model
(
   input wire logic clock,
   output logic [7:0] regAddr,
   output logic [15:0] regWrData,
   output logic regWrEn,
   input wire logic [15:0] regRdData
);
   // idle bus at time zero
   initial
   begin
      regAddr = 8'h00;
      regWrData = 16'h0000;
      regWrEn = 1'b0;
   end
   // ========================================================================
   // one write, data scrambled once released so stale values never match
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clock);
      regWrEn <= 1'b0;
      regWrData <= ~d;
   endtask
   // read waits the one-edge register latency plus a sampling edge
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      @(posedge clock);
      @(posedge clock);
      d = regRdData;
   endtask
endmodule // amvc_host_model

// ### verification/test_audio_format_mute_volume_ctrl.sv
// Purpose: self-checking bench for the volume/mute control
// Assumes: ramp step periods shortened to a few cycles
// Notes: ramp lengths are judged within one step period
`timescale 1ns/1ps
module test_audio_format_mute_volume_ctrl;
   localparam int lenTab [4] = '{256, 512, 1024, 2048};
   localparam int perTab [4] = '{8, 6, 5, 8};
   localparam logic [2:0] codeTab [4] = '{3'h3, 3'h0, 3'h1, 3'h2};
   localparam amvc_pkg::amvc_fs_t fsTab [4] = '{amvc_pkg::FS_8K, amvc_pkg::FS_44K,
      amvc_pkg::FS_48K, amvc_pkg::FS_8K};
   logic clock, rst, regWrEn, speakerFault, pinExt, pinLevel;
   logic [7:0] regAddr;
   logic [15:0] regWrData, regRdData, masterGain, ch1Gain, ch2Gain;
   logic [2:0] halfDutyMute;
   logic fmtRsvd, allShutdown, ternaryMode, rampBusy, pinOut, pinOe, busAddrSel;
   amvc_pkg::amvc_fs_t fsFamily;
   amvc_pkg::amvc_fmt_t rxFormat;
   amvc_pkg::amvc_wlen_t rxWordLen;
   int nMismatch = 0;
   int totalChecks = 0;
   int cyc = 0;
   int n;
   // shared pin: the device wins while it drives
   assign pinLevel = pinOe ? pinOut : pinExt;
   amvc_host_model host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdData(regRdData));
   amvc_ctrl #(.STEP_8K_CYC(8), .STEP_44K_CYC(6), .STEP_48K_CYC(5)) dut
   (
      .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdData(regRdData), .fsFamily(fsFamily),
      .speakerFault(speakerFault), .rxFormat(rxFormat), .rxWordLen(rxWordLen),
      .fmtCodeReserved(fmtRsvd), .allShutdown(allShutdown), .ternaryMode(ternaryMode),
      .halfDutyMute(halfDutyMute), .masterGain(masterGain), .ch1Gain(ch1Gain),
      .ch2Gain(ch2Gain), .rampBusy(rampBusy), .addrSelFaultPinIn(pinLevel),
      .addrSelFaultPinOut(pinOut), .addrSelFaultPinOe(pinOe), .busAddrSel(busAddrSel)
   );
   // ========================================================================
   // clock and hang guard
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         nMismatch++;
         stopTest();
      end
   end
   // ========================================================================
   // compare and bus helpers
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chkTime(input string name, input int lo, input int hi, input int got);
      totalChecks++;
      if (got < lo || got > hi)
      begin
         nMismatch++;
         $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [15:0] exp, input string name);
      logic [15:0] d;
      host.rd(a, d);
      chk(name, d, exp);
   endtask
   // cycles from a write until no gain is moving
   task automatic waitRamp(output int c);
      c = 3;
      repeat (3) @(posedge clock);
      while (rampBusy !== 1'b0 && c < 20000)
      begin
         @(posedge clock);
         c++;
      end
   endtask
   // step size is fixed per change, so a 1023-code move takes this many steps
   function automatic int steps(input int len);
      int s;
      s = (1023 + len - 1) / len;
      return (1023 + s - 1) / s;
   endfunction
   task automatic stopTest();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ========================================================================
   // main sequence
   initial
   begin
      rst = 1'b1;
      fsFamily = amvc_pkg::FS_8K;
      speakerFault = 1'b0;
      pinExt = 1'b0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rdChk(8'h03, 16'h0080, "sysctl1");
      rdChk(8'h04, 16'h0005, "serfmt");
      rdChk(8'h05, 16'h0040, "sysctl2");
      rdChk(8'h06, 16'h0000, "softmute");
      rdChk(8'h07, 16'h03FF, "mastervol");
      rdChk(8'h08, 16'h00C0, "ch1vol");
      rdChk(8'h09, 16'h00C0, "ch2vol");
      rdChk(8'h0E, 16'h00F0, "slewcfg");
      chk("format", {12'h000, rxFormat, rxWordLen}, 16'h0006);
      chk("shutdown", {15'h0000, allShutdown}, 16'h0001);
      chk("pinOe", {15'h0000, pinOe}, 16'h0000);
      // every format code, then one reserved code
      for (int c = 0; c < 10; c++)
      begin
         host.wr(8'h04, 16'(c));
         repeat (2) @(posedge clock);
         chk("format", {12'h000, rxFormat, rxWordLen}, (c < 9) ? 16'((c / 3) * 4 + c % 3) : 16'h000A);
         chk("reserved", {15'h0000, fmtRsvd}, (c < 9) ? 16'h0000 : 16'h0001);
      end
      host.wr(8'h20, 16'h00FF);
      rdChk(8'h20, 16'h0000, "unmapped");
      rdChk(8'h04, 16'h0009, "serfmt");
      host.wr(8'h07, 16'h0000);
      host.wr(8'h08, 16'h0060);
      host.wr(8'h09, 16'h0120);
      rdChk(8'h09, 16'h0120, "ch2vol");
      host.wr(8'h06, 16'h00FF);
      rdChk(8'h06, 16'h0007, "softmute");
      chk("halfDuty", {13'h0000, halfDutyMute}, 16'h0007);
      host.wr(8'h06, 16'h0002);
      host.wr(8'h06, 16'h0000);
      // hard unmute with ternary and fault output on
      host.wr(8'h03, 16'h00A0);
      host.wr(8'h05, 16'h000A);
      repeat (4) @(posedge clock);
      chk("shutdown", {15'h0000, allShutdown}, 16'h0000);
      chk("master", masterGain, 16'h0000);
      chk("ch1", ch1Gain, 16'h0060);
      chk("ch2", ch2Gain, 16'h0120);
      chk("ternary", {15'h0000, ternaryMode}, 16'h0001);
      speakerFault <= 1'b1;
      repeat (2) @(posedge clock);
      chk("pinOut", {13'h0000, pinOe, pinOut, busAddrSel}, 16'h0006);
      speakerFault <= 1'b0;
      host.wr(8'h05, 16'h0000);
      pinExt <= 1'b1;
      repeat (4) @(posedge clock);
      chk("addrSel", {14'h0000, pinOe, busAddrSel}, 16'h0001);
      // every slew length once, under rate families 8K, 44K, 48K and 8K in turn
      for (int k = 0; k < 4; k++)
      begin
         fsFamily <= fsTab[k];
         host.wr(8'h0E, {13'h0000, codeTab[k]});
         host.wr(8'h07, k[0] ? 16'h0000 : 16'h03FF);
         waitRamp(n);
         chkTime("ramp", (steps(lenTab[k]) - 1) * perTab[k], (steps(lenTab[k]) + 1) * perTab[k] + 4, n);
      end
      host.wr(8'h05, 16'h0040);
      repeat (4) @(posedge clock);
      chk("muted", masterGain & ch1Gain, 16'h03FF);
      // soft unmute follows the slew setting
      host.wr(8'h03, 16'h0080);
      host.wr(8'h0E, 16'h0003);
      host.wr(8'h0E, 16'h0007);
      host.wr(8'h05, 16'h0000);
      waitRamp(n);
      chkTime("unmute", 255 * 8, 257 * 8 + 4, n);
      chk("master", masterGain, 16'h0000);
      stopTest();
   end
endmodule // test_audio_format_mute_volume_ctrl
